//--- hcd_params.svh
// Purpose: offsets, field positions, reset values for the config decoder
// Assumes: included by bare name
// Notes:   erased flash reads as all ones
`ifndef HCD_PARAMS_SVH
`define HCD_PARAMS_SVH
`define HCD_SFR_CFG_ADDR   8'h93
`define HCD_SFR_CFG_DATA   8'h94
`define HCD_IDX_SEC_MEM    7'h7F
`define HCD_IDX_SUP_PORTS  7'h7E
`define HCD_ERASED_BYTE    8'hFF
`define HCD_SFR_RESET      8'h00
`define HCD_B0_SECURITY    7
`define HCD_B0_PML         6
`define HCD_B0_RSL         5
`define HCD_B0_BOOTROM     4
`define HCD_B0_WDRST       3
`define HCD_B0_DATA_FLASH_SIZE_SELECT_HI    2
`define HCD_B0_DATA_FLASH_SIZE_SELECT_LO    0
`define HCD_B1_DBL_HI      7
`define HCD_B1_DBL_LO      6
`define HCD_B1_ABL_HI      5
`define HCD_B1_ABL_LO      4
`define HCD_B1_DAB         3
`define HCD_B1_DDB         2
`define HCD_B1_PORT0_GPIO_ENABLE        1
`define HCD_B1_PORT2_3_GPIO_ENABLE       0
`endif

//--- hcd_pkg.sv
// Purpose: types for the hardware configuration decoder
// Assumes: nothing
// Notes:   struct field order follows the two stored bytes
package hcd_pkg;
  typedef enum logic [1:0] {
    HCD_BO_4V5,
    HCD_BO_4V2,
    HCD_BO_2V7,
    HCD_BO_2V5
  } hcd_bo_level_t;

  typedef enum logic [2:0] {
    HCD_DF_RESERVED,
    HCD_DF_UPTO_32K,
    HCD_DF_UPTO_16K,
    HCD_DF_UPTO_8K,
    HCD_DF_4K,
    HCD_DF_2K,
    HCD_DF_1K,
    HCD_DF_NONE
  } hcd_df_size_t;

  typedef struct packed {
    logic          securityAccessEnable;
    logic          programMemoryLock;
    logic          resetSectorLock;
    logic          bootRomEnable;
    logic          watchdogResetEnable;
    hcd_df_size_t  dataFlashSizeSelect;
    hcd_bo_level_t digitalBrownoutThreshold;
    hcd_bo_level_t analogBrownoutThreshold;
    logic          analogBrownoutDisable;
    logic          digitalBrownoutDisable;
    logic          port0GpioEnable;
    logic          port23GpioEnable;
  } hcd_cfg_t;
endpackage

//--- hcd_config_decoder.sv
// Purpose: configuration byte store, indirect read port and field decode
// Assumes: progMode comes from strap logic on the same clock
// Notes:   store has no reset so it survives resets like flash
`timescale 1ns/10ps
`include "hcd_params.svh"
// Overview of operation
// - security clear: program mode only via user mode
// - program lock set blocks flash writes
// - program lock overrides reset sector lock
// - reset sector lock makes sector read-only
// - boot rom enable field drives boot rom
// - watchdog reset enable field gates watchdog reset
// - decode three-bit data flash size field
// - decode digital brownout threshold field
// - decode analog brownout threshold, same encoding
// - analog brownout disabled only above two volts
// - digital brownout disable field gates reset
// - port0 field selects gpio or external bus
// - port2/3 field selects gpio or external bus
// - config bytes change only in program mode
// - address register selects, data register returns byte
// - 128 bytes behind address and data registers
// - secured bytes change only by mass erase
// - erased bytes read as all ones
module hcd_config_decoder #(
  parameter int DEPTH = 128
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            sfrAddr,
  input  wire logic [7:0]            sfrWrData,
  input  wire logic                  sfrWr,
  input  wire logic                  sfrRd,
  output logic [7:0]                 sfrRdData,
  input  wire logic                  progMode,
  input  wire logic                  massErase,
  input  wire logic                  avddAbove2v,
  output hcd_pkg::hcd_cfg_t          cfg,
  output logic                       flashAccessUamOnly,
  output logic                       progFlashWriteEnable,
  output logic                       uamFlashWriteEnable,
  output logic                       resetSectorWriteEnable,
  output logic                       bootRomEnable,
  output logic                       watchdogResetEnable,
  output hcd_pkg::hcd_df_size_t      dataFlashSize,
  output hcd_pkg::hcd_bo_level_t     digitalBrownoutLevel,
  output hcd_pkg::hcd_bo_level_t     analogBrownoutLevel,
  output logic                       analogBrownoutResetEnable,
  output logic                       digitalBrownoutResetEnable,
  output logic                       port0ExtBus,
  output logic                       port2ExtBus,
  output logic                       port3StrobeEnable
);
  typedef enum logic {HCD_LOAD, HCD_RUN} hcd_state_t;

  logic [7:0]        cfgMem [DEPTH];
  logic [7:0]        configAddressSelect;
  logic [7:0]        next_configAddressSelect;
  logic [7:0]        next_sfrRdData;
  hcd_pkg::hcd_cfg_t next_cfg;
  hcd_state_t        state;
  hcd_state_t        next_state;
  logic [2:0]        avddSync;
  logic              avddStable;
  logic              next_avddStable;
  logic              memWe;
  logic              eraseAll;
  logic [6:0]        selIdx;
  logic              secured;

  function automatic hcd_pkg::hcd_cfg_t decodeBytes(input logic [7:0] b0,
                                                    input logic [7:0] b1);
    hcd_pkg::hcd_cfg_t c;
    c.securityAccessEnable     = b0[`HCD_B0_SECURITY];
    c.programMemoryLock        = b0[`HCD_B0_PML];
    c.resetSectorLock          = b0[`HCD_B0_RSL];
    c.bootRomEnable            = b0[`HCD_B0_BOOTROM];
    c.watchdogResetEnable      = b0[`HCD_B0_WDRST];
    c.dataFlashSizeSelect      =
      hcd_pkg::hcd_df_size_t'(b0[`HCD_B0_DATA_FLASH_SIZE_SELECT_HI:`HCD_B0_DATA_FLASH_SIZE_SELECT_LO]);
    c.digitalBrownoutThreshold =
      hcd_pkg::hcd_bo_level_t'(b1[`HCD_B1_DBL_HI:`HCD_B1_DBL_LO]);
    c.analogBrownoutThreshold  =
      hcd_pkg::hcd_bo_level_t'(b1[`HCD_B1_ABL_HI:`HCD_B1_ABL_LO]);
    c.analogBrownoutDisable    = b1[`HCD_B1_DAB];
    c.digitalBrownoutDisable   = b1[`HCD_B1_DDB];
    c.port0GpioEnable          = b1[`HCD_B1_PORT0_GPIO_ENABLE];
    c.port23GpioEnable         = b1[`HCD_B1_PORT2_3_GPIO_ENABLE];
    return c;
  endfunction

  assign selIdx  = configAddressSelect[6:0];
  assign secured = !cfg.securityAccessEnable;

  // store writes: program mode only, secured bytes only through erase
  always_comb begin
    eraseAll = progMode && massErase;
    memWe    = progMode && sfrWr && (sfrAddr == `HCD_SFR_CFG_DATA) && !eraseAll;
    if (secured && ((selIdx == `HCD_IDX_SEC_MEM) || (selIdx == `HCD_IDX_SUP_PORTS))) begin
      memWe = 1'b0;
    end
  end

  // no reset: contents must persist across resets
  always_ff @(posedge clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (eraseAll) begin
        cfgMem[i] <= `HCD_ERASED_BYTE;
      end else if (memWe && (selIdx == 7'(i))) begin
        cfgMem[i] <= sfrWrData;
      end
    end
  end

  // register port: address is ordinary storage, data is indirect
  always_comb begin
    next_configAddressSelect = configAddressSelect;
    next_sfrRdData           = sfrRdData;
    if (sfrWr && (sfrAddr == `HCD_SFR_CFG_ADDR)) begin
      next_configAddressSelect = sfrWrData;
    end
    if (sfrRd) begin
      if (sfrAddr == `HCD_SFR_CFG_ADDR) begin
        next_sfrRdData = configAddressSelect;
      end else if (sfrAddr == `HCD_SFR_CFG_DATA) begin
        next_sfrRdData = cfgMem[selIdx];
      end else begin
        next_sfrRdData = `HCD_SFR_RESET;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      configAddressSelect <= `HCD_SFR_RESET;
      sfrRdData           <= `HCD_SFR_RESET;
    end else begin
      configAddressSelect <= next_configAddressSelect;
      sfrRdData           <= next_sfrRdData;
    end
  end

  // latch once after release; later programming waits for next reset
  always_comb begin
    next_state = state;
    next_cfg   = cfg;
    case (state)
      HCD_LOAD: begin
        next_cfg   = decodeBytes(cfgMem[`HCD_IDX_SEC_MEM], cfgMem[`HCD_IDX_SUP_PORTS]);
        next_state = HCD_RUN;
      end
      HCD_RUN: begin
        next_state = HCD_RUN;
      end
      default: begin
        next_state = HCD_LOAD;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= HCD_LOAD;
      cfg   <= hcd_pkg::hcd_cfg_t'({`HCD_ERASED_BYTE, `HCD_ERASED_BYTE});
    end else begin
      state <= next_state;
      cfg   <= next_cfg;
    end
  end

  // analog comparator is asynchronous; take it once two stages agree
  always_comb begin
    next_avddStable = avddStable;
    if (avddSync[1] == avddSync[2]) begin
      next_avddStable = avddSync[2];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avddSync   <= 3'h0;
      avddStable <= 1'b0;
    end else begin
      avddSync   <= {avddSync[1:0], avddAbove2v};
      avddStable <= next_avddStable;
    end
  end

  // decoded controls
  assign flashAccessUamOnly         = progMode && secured;
  assign progFlashWriteEnable       = !cfg.programMemoryLock;
  assign uamFlashWriteEnable        = !cfg.programMemoryLock;
  assign resetSectorWriteEnable     = !cfg.programMemoryLock && !cfg.resetSectorLock;
  assign bootRomEnable              = cfg.bootRomEnable;
  assign watchdogResetEnable        = cfg.watchdogResetEnable;
  assign dataFlashSize              = cfg.dataFlashSizeSelect;
  assign digitalBrownoutLevel       = cfg.digitalBrownoutThreshold;
  assign analogBrownoutLevel        = cfg.analogBrownoutThreshold;
  // below two volts the disable bit cannot hold the reset off
  assign analogBrownoutResetEnable  = !cfg.analogBrownoutDisable || !avddStable;
  assign digitalBrownoutResetEnable = !cfg.digitalBrownoutDisable;
  assign port0ExtBus                = !cfg.port0GpioEnable;
  assign port2ExtBus                = !cfg.port23GpioEnable;
  assign port3StrobeEnable          = !cfg.port0GpioEnable || !cfg.port23GpioEnable;

  sequence s_securedWrite;
    secured && progMode && sfrWr && !massErase && (sfrAddr == `HCD_SFR_CFG_DATA)
      && (selIdx == `HCD_IDX_SEC_MEM);
  endsequence

  property p_cfgHeld;
    @(posedge clock) disable iff (sys_rst)
      (state == HCD_RUN) ##1 (state == HCD_RUN) |-> $stable(cfg);
  endproperty
  a_cfgHeld: assert property (p_cfgHeld) else $error("config changed after load");

  property p_loadFromStore;
    @(posedge clock) disable iff (sys_rst)
      (state == HCD_LOAD) |=> cfg.securityAccessEnable == $past(cfgMem[`HCD_IDX_SEC_MEM][7]);
  endproperty
  a_loadFromStore: assert property (p_loadFromStore) else $error("bad load");

  property p_noWriteOutsideProg;
    @(posedge clock) disable iff (sys_rst)
      !progMode |=> $stable(cfgMem[`HCD_IDX_SUP_PORTS]);
  endproperty
  a_noWriteOutsideProg: assert property (p_noWriteOutsideProg) else $error("user write");

  property p_securedRefused;
    @(posedge clock) disable iff (sys_rst)
      s_securedWrite |=> $stable(cfgMem[`HCD_IDX_SEC_MEM]);
  endproperty
  a_securedRefused: assert property (p_securedRefused) else $error("secured write");

  property p_eraseOnes;
    @(posedge clock) disable iff (sys_rst)
      progMode && massErase |=> (cfgMem[`HCD_IDX_SEC_MEM] == `HCD_ERASED_BYTE)
        && (cfgMem[`HCD_IDX_SUP_PORTS] == `HCD_ERASED_BYTE);
  endproperty
  a_eraseOnes: assert property (p_eraseOnes) else $error("erase not all ones");

  property p_readBack;
    @(posedge clock) disable iff (sys_rst)
      sfrRd && (sfrAddr == `HCD_SFR_CFG_DATA) |=> sfrRdData == $past(cfgMem[selIdx]);
  endproperty
  a_readBack: assert property (p_readBack) else $error("indirect read wrong");

  property p_lockPriority;
    @(posedge clock) disable iff (sys_rst)
      cfg.programMemoryLock |-> !resetSectorWriteEnable && !uamFlashWriteEnable;
  endproperty
  a_lockPriority: assert property (p_lockPriority) else $error("lock priority broken");

  property p_analogLow;
    @(posedge clock) disable iff (sys_rst)
      // sync chain plus agreement stage: low supply is honoured on the fifth cycle
      (!avddAbove2v) [*5] |-> analogBrownoutResetEnable;
  endproperty
  a_analogLow: assert property (p_analogLow) else $error("analog reset off");

  property p_strobes;
    @(posedge clock) disable iff (sys_rst)
      (port0ExtBus || port2ExtBus) |-> port3StrobeEnable;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes not taken");
endmodule

//--- test_hw_config_byte_decoder.sv
// Purpose: self-checking bench for the configuration byte decoder
// Assumes: store contents are unknown until the first mass erase
// Notes:   decoded fields are compared after each reset, after programming without one and after supply changes
`timescale 1ns/10ps
`include "hcd_params.svh"
module test_hw_config_byte_decoder;
  logic                   clock;
  logic                   sys_rst;
  logic [7:0]             sfrAddr;
  logic [7:0]             sfrWrData;
  logic                   sfrWr;
  logic                   sfrRd;
  logic [7:0]             sfrRdData;
  logic                   progMode;
  logic                   massErase;
  logic                   avddAbove2v;
  hcd_pkg::hcd_cfg_t      cfg;
  logic                   flashAccessUamOnly;
  logic                   progFlashWriteEnable;
  logic                   uamFlashWriteEnable;
  logic                   resetSectorWriteEnable;
  logic                   bootRomEnable;
  logic                   watchdogResetEnable;
  hcd_pkg::hcd_df_size_t  dataFlashSize;
  hcd_pkg::hcd_bo_level_t digitalBrownoutLevel;
  hcd_pkg::hcd_bo_level_t analogBrownoutLevel;
  logic                   analogBrownoutResetEnable;
  logic                   digitalBrownoutResetEnable;
  logic                   port0ExtBus;
  logic                   port2ExtBus;
  logic                   port3StrobeEnable;
  int                     fail_count;
  int                     cmp_count;
  logic [7:0]             rdVal;
  logic [7:0]             b0;
  logic [7:0]             b1;

  hcd_config_decoder dut (
    .clock                      (clock),
    .sys_rst                    (sys_rst),
    .sfrAddr                    (sfrAddr),
    .sfrWrData                  (sfrWrData),
    .sfrWr                      (sfrWr),
    .sfrRd                      (sfrRd),
    .sfrRdData                  (sfrRdData),
    .progMode                   (progMode),
    .massErase                  (massErase),
    .avddAbove2v                (avddAbove2v),
    .cfg                        (cfg),
    .flashAccessUamOnly         (flashAccessUamOnly),
    .progFlashWriteEnable       (progFlashWriteEnable),
    .uamFlashWriteEnable        (uamFlashWriteEnable),
    .resetSectorWriteEnable     (resetSectorWriteEnable),
    .bootRomEnable              (bootRomEnable),
    .watchdogResetEnable        (watchdogResetEnable),
    .dataFlashSize              (dataFlashSize),
    .digitalBrownoutLevel       (digitalBrownoutLevel),
    .analogBrownoutLevel        (analogBrownoutLevel),
    .analogBrownoutResetEnable  (analogBrownoutResetEnable),
    .digitalBrownoutResetEnable (digitalBrownoutResetEnable),
    .port0ExtBus                (port0ExtBus),
    .port2ExtBus                (port2ExtBus),
    .port3StrobeEnable          (port3StrobeEnable)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfrWr     <= 1'b1;
    sfrAddr   <= a;
    sfrWrData <= d;
    @(posedge clock);
    sfrWr     <= 1'b0;
  endtask

  // data lands on the sampling edge itself and then stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfrRd   <= 1'b1;
    sfrAddr <= a;
    @(posedge clock);
    sfrRd   <= 1'b0;
    #1 d = sfrRdData;
  endtask

  task automatic erase();
    @(posedge clock);
    massErase <= 1'b1;
    @(posedge clock);
    massErase <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    // supply sync restarts low; let it settle before comparing
    repeat (5) @(posedge clock);
    #1;
  endtask

  task automatic check_outs(input logic [7:0] c0, input logic [7:0] c1);
    logic [33:0] exp;
    exp = {c0, c1, progMode & ~c0[7], ~c0[6], ~c0[6], ~c0[6] & ~c0[5], c0[4], c0[3],
           c0[2:0], c1[7:6], c1[5:4], ~c1[3] | ~avddAbove2v, ~c1[2], ~c1[1], ~c1[0],
           ~c1[1] | ~c1[0]};
    cmp({cfg, flashAccessUamOnly, progFlashWriteEnable, uamFlashWriteEnable,
         resetSectorWriteEnable, bootRomEnable, watchdogResetEnable, dataFlashSize,
         digitalBrownoutLevel, analogBrownoutLevel, analogBrownoutResetEnable,
         digitalBrownoutResetEnable, port0ExtBus, port2ExtBus, port3StrobeEnable}, exp);
  endtask

  task automatic program_pair(input logic [7:0] c0, input logic [7:0] c1);
    progMode <= 1'b1;
    wr(`HCD_SFR_CFG_ADDR, {1'b0, `HCD_IDX_SEC_MEM});
    wr(`HCD_SFR_CFG_DATA, c0);
    wr(`HCD_SFR_CFG_ADDR, {1'b0, `HCD_IDX_SUP_PORTS});
    wr(`HCD_SFR_CFG_DATA, c1);
  endtask

  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  initial begin
    fail_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    progMode = 1'b1;
    // store is unknown at power-up; erase it while reset holds
    massErase = 1'b1;
    avddAbove2v = 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    massErase <= 1'b0;
    erase();
    rd(`HCD_SFR_CFG_ADDR, rdVal);
    cmp(34'(rdVal), 34'(`HCD_SFR_RESET));
    wr(`HCD_SFR_CFG_ADDR, {1'b0, `HCD_IDX_SEC_MEM});
    rd(`HCD_SFR_CFG_DATA, rdVal);
    cmp(34'(rdVal), 34'(`HCD_ERASED_BYTE));
    rd(8'h95, rdVal);
    cmp(34'(rdVal), 34'h0);
    do_reset();
    check_outs(8'hFF, 8'hFF);
    b0 = 8'hFF;
    b1 = 8'hFF;
    // every size code and every brownout level, both lock orders
    for (int i = 0; i < 8; i++) begin
      program_pair({1'b1, i[0], i[1], i[2], ~i[0], i[2:0]},
                   {i[1:0], ~i[1:0], i[0], i[1], i[2], ~i[2]});
      #1 check_outs(b0, b1);
      b0 = {1'b1, i[0], i[1], i[2], ~i[0], i[2:0]};
      b1 = {i[1:0], ~i[1:0], i[0], i[1], i[2], ~i[2]};
      progMode <= i[1];
      do_reset();
      check_outs(b0, b1);
    end
    cmp(34'({dataFlashSize, digitalBrownoutLevel}),
        34'({hcd_pkg::HCD_DF_NONE, hcd_pkg::HCD_BO_2V5}));
    // analog disable only holds while the supply is above two volts
    avddAbove2v <= 1'b0;
    repeat (6) @(posedge clock);
    #1 check_outs(b0, b1);
    avddAbove2v <= 1'b1;
    repeat (6) @(posedge clock);
    #1 check_outs(b0, b1);
    progMode <= 1'b0;
    wr(`HCD_SFR_CFG_ADDR, {1'b0, `HCD_IDX_SEC_MEM});
    wr(`HCD_SFR_CFG_DATA, 8'h00);
    rd(`HCD_SFR_CFG_DATA, rdVal);
    cmp(34'(rdVal), 34'(b0));
    program_pair(8'h7F, b1);
    do_reset();
    check_outs(8'h7F, b1);
    wr(`HCD_SFR_CFG_ADDR, {1'b0, `HCD_IDX_SEC_MEM});
    wr(`HCD_SFR_CFG_DATA, 8'hFF);
    rd(`HCD_SFR_CFG_DATA, rdVal);
    cmp(34'(rdVal), 34'h7F);
    erase();
    rd(`HCD_SFR_CFG_DATA, rdVal);
    cmp(34'(rdVal), 34'(`HCD_ERASED_BYTE));
    stop_test();
  end
endmodule
